//--- fpau_pkg.sv
package fpau_pkg;

	// ----------------------------------------
	// word format
	// ----------------------------------------
	typedef struct packed {
		logic        sign;
		logic [14:0] exp;
		logic [47:0] coef;
	} fpau_word_t;

	typedef enum logic [1:0] {
		MUL_TRUNC,
		MUL_FULL_ROUND,
		MUL_HALF,
		MUL_ITERATE
	} fpau_mul_mode_t;

	// ----------------------------------------
	// exponent limits (octal 40000, 60000, 20000, 20001, 60002)
	// ----------------------------------------
	localparam logic [14:0] EXP_BIAS   = 15'h4000;
	localparam logic [14:0] EXP_OVF    = 15'h6000;
	localparam logic [14:0] EXP_UNF    = 15'h2000;
	localparam logic [14:0] RCP_ERR_LO = 15'h2001;
	localparam logic [14:0] RCP_ERR_HI = 15'h6002;
	localparam logic [16:0] RCP_EXP_BASE = 17'h08001;

	// ----------------------------------------
	// datapath constants
	// ----------------------------------------
	localparam logic [15:0] ADD_SHIFT_LIMIT = 16'h0031;
	localparam logic [95:0] MUL_COMP        = 96'h00000000_00000900_00000000;
	localparam logic [95:0] MUL_RND_FULL    = 96'h00000000_00006000_00000000;
	localparam logic [95:0] MUL_RND_HALF    = 96'h00000003_00000000_00000000;
	localparam logic [47:0] HALF_MASK       = 48'hFFFFFFF80000;
	localparam logic [50:0] ITER_TWO        = 51'h2000000000000;
	localparam logic [16:0] ITER_EXP_BASE   = 17'h04003;
	localparam logic [16:0] ITER_SHIFT_MAX  = 17'h00032;
	localparam logic [31:0] NEWTON_TWO      = 32'h80000000;

	// ----------------------------------------
	// reciprocal seed, Q2.14, indexed by the three bits below the leading one
	// ----------------------------------------
	localparam logic [15:0] RCP_SEED [0:7] = '{16'h7878, 16'h6BCA, 16'h618A, 16'h590B,
		16'h51EC, 16'h4BDA, 16'h469F, 16'h4211};

	localparam int ADD_LAT = 2;
	localparam int MUL_LAT = 2;
	localparam int RCP_LAT = 4;

endpackage

//--- fpau_units.sv
`timescale 1ns/1ps
//
// Function
// RQ1: multiply checks range before normalizing shift
// RQ2: both exponents zero gives unshifted integer multiply
// RQ3: integer result is 48 bits from top
// RQ4: integer sign is sign product, sign-magnitude
// RQ5: integer multiply still adds compensation constant
// RQ6: reciprocal errors at exponent 20001 or 60002
// RQ7: reciprocal error returns 60000, coefficient top cleared
// RQ8: add uses 49-bit register, trial exponent subtraction
// RQ9: larger exponent sign; smaller coefficient shifted right
// RQ10: alignment drops shifted-out bits without rounding
// RQ11: carry out drops low bit, bumps exponent
// RQ12: add normalizes: right one or left 48
// RQ13: add underflow unflagged; checks beside normalization; code flags an exponent below zero, as for zero plus zero
// RQ14: zero plus valid operand yields normalized operand
// RQ15: 95-bit product shifts left, exponent decremented
// RQ16: truncation adds nine carries at two^-56
// RQ17: multiply result independent of operand order
// RQ18: rounded mode selectable per operation
// RQ19: full rounding injects bits at -50, -51
// RQ20: half precision rounds at -32,-31, 29 bits
// RQ21: reciprocal fully pipelined, one per cycle
// RQ22: table seed then three Newton steps
// RQ23: iteration mode returns two minus product
// RQ24: exponents biased by octal 40000
// RQ25: add exponent at least 60000 flags error
// RQ26: error flag arrives with its result
// RQ27: fixed latency, back-to-back operands, no stall
//
module fpau_units
	import fpau_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// add unit
	input  wire logic       addValid,
	input  wire fpau_word_t addOpA,
	input  wire fpau_word_t addOpB,
	input  wire logic       addSubtract,
	output logic            addResValid,
	output fpau_word_t      addRes,
	output logic            addErr,
	// multiply unit
	input  wire logic           mulValid,
	input  wire fpau_word_t     mulOpA,
	input  wire fpau_word_t     mulOpB,
	input  wire fpau_mul_mode_t mulMode,
	output logic                mulResValid,
	output fpau_word_t          mulRes,
	output logic                mulErr,
	// reciprocal unit
	input  wire logic       rcpValid,
	input  wire fpau_word_t rcpOp,
	output logic            rcpResValid,
	output fpau_word_t      rcpRes,
	output logic            rcpErr
);

	function automatic logic [6:0] lzc64(input logic [63:0] v);
		logic [6:0] n;
		logic       found;
		n = 7'h40;
		found = 1'b0;
		for (int i = 63; i >= 0; i--) begin
			if (!found && v[i]) begin
				n = 7'(63 - i);
				found = 1'b1;
			end
		end
		return n;
	endfunction

	function automatic logic [31:0] newtonStep(input logic [31:0] x, input logic [31:0] b);
		logic [63:0] t;
		logic [31:0] corr;
		logic [63:0] p;
		t = x * b;
		corr = NEWTON_TWO - t[63:32];
		p = x * corr;
		return p[61:30];
	endfunction

	// ----------------------------------------
	// add: alignment stage
	// ----------------------------------------
	logic        bSignEff;
	logic [15:0] expDiff;
	logic        aIsBig;
	logic [15:0] shiftAmt;
	fpau_word_t  bigOp;
	fpau_word_t  smallOp;
	logic [48:0] smallAligned;
	logic [48:0] bigExt;
	logic [48:0] sum49;
	logic        sumSign;
	logic        add1Valid_reg;
	logic [48:0] addSum_reg;
	logic [14:0] addExp_reg;
	logic        addSign_reg;
	logic        addOvf_reg;

	always_comb begin
		bSignEff = addOpB.sign ^ addSubtract;
		expDiff = {1'b0, addOpA.exp} - {1'b0, addOpB.exp}; // RQ8
		aIsBig = ~expDiff[15];
		bigOp = aIsBig ? addOpA : '{bSignEff, addOpB.exp, addOpB.coef}; // RQ9
		smallOp = aIsBig ? '{bSignEff, addOpB.exp, addOpB.coef} : addOpA;
		shiftAmt = aIsBig ? expDiff : 16'(-expDiff);
		bigExt = {1'b0, bigOp.coef};
		smallAligned = (shiftAmt >= ADD_SHIFT_LIMIT) ? '0 : ({1'b0, smallOp.coef} >> shiftAmt); // RQ9 RQ10
		if (bigOp.sign == smallOp.sign) begin
			sum49 = bigExt + smallAligned;
			sumSign = bigOp.sign;
		end else if (bigExt >= smallAligned) begin
			sum49 = bigExt - smallAligned;
			sumSign = bigOp.sign;
		end else begin
			sum49 = smallAligned - bigExt;
			sumSign = ~bigOp.sign;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			add1Valid_reg <= 1'b0;
			addSum_reg <= '0;
			addExp_reg <= '0;
			addSign_reg <= 1'b0;
			addOvf_reg <= 1'b0;
		end else begin
			add1Valid_reg <= addValid; // RQ27
			addSum_reg <= sum49;
			addExp_reg <= bigOp.exp;
			addSign_reg <= sumSign;
			addOvf_reg <= (bigOp.exp >= EXP_OVF); // RQ25
		end
	end

	// ----------------------------------------
	// add: normalize and range stage
	// ----------------------------------------
	logic [6:0]  addLz;
	logic [16:0] addExpN;
	logic [47:0] addCoefN;
	fpau_word_t  addRes_next;
	logic        addErr_next;

	always_comb begin
		addLz = lzc64({addSum_reg[47:0], 16'h0000});
		if (addSum_reg[48]) begin
			addCoefN = addSum_reg[48:1]; // RQ11
			addExpN = {2'b00, addExp_reg} + 17'h00001;
		end else begin
			addCoefN = addSum_reg[47:0] << addLz; // RQ12 RQ14
			addExpN = {2'b00, addExp_reg} - {10'h000, addLz};
		end
		addErr_next = 1'b0;
		if (addOvf_reg || (!addExpN[16] && addExpN[14:0] >= EXP_OVF) || addExpN[15]) begin
			addRes_next = '{addSign_reg, EXP_OVF, addCoefN}; // RQ25
			addErr_next = 1'b1;
		end else if (addSum_reg == '0 || addExpN[16] || addExpN[14:0] < EXP_UNF) begin
			addRes_next = '0; // RQ13
		end else begin
			addRes_next = '{addSign_reg, addExpN[14:0], addCoefN};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			addResValid <= 1'b0;
			addRes <= '0;
			addErr <= 1'b0;
		end else begin
			addResValid <= add1Valid_reg;
			addRes <= addRes_next;
			addErr <= addErr_next; // RQ26
		end
	end

	// ----------------------------------------
	// multiply: product stage
	// ----------------------------------------
	logic [95:0]    mulInject;
	logic           mul1Valid_reg;
	logic [95:0]    mulProd_reg;
	logic [16:0]    mulExp_reg;
	logic           mulInt_reg;
	logic           mulSign_reg;
	fpau_mul_mode_t mulMode_reg;

	always_comb begin
		case (mulMode)
			MUL_FULL_ROUND: mulInject = MUL_RND_FULL; // RQ18 RQ19
			MUL_HALF:       mulInject = MUL_RND_HALF; // RQ20
			default:        mulInject = MUL_COMP; // RQ5 RQ16
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mul1Valid_reg <= 1'b0;
			mulProd_reg <= '0;
			mulExp_reg <= '0;
			mulInt_reg <= 1'b0;
			mulSign_reg <= 1'b0;
			mulMode_reg <= MUL_TRUNC;
		end else begin
			mul1Valid_reg <= mulValid;
			mulProd_reg <= (mulOpA.coef * mulOpB.coef) + mulInject; // RQ15 RQ17
			mulExp_reg <= {2'b00, mulOpA.exp} + {2'b00, mulOpB.exp} - {2'b00, EXP_BIAS}; // RQ24
			mulInt_reg <= (mulOpA.exp == '0) && (mulOpB.exp == '0); // RQ2
			mulSign_reg <= mulOpA.sign ^ mulOpB.sign; // RQ4
			mulMode_reg <= mulMode;
		end
	end

	// ----------------------------------------
	// multiply: range, normalize, mode stage
	// ----------------------------------------
	logic        mulOvf;
	logic        mulUnf;
	logic [47:0] mulCoefN;
	logic [16:0] mulExpN;
	logic [16:0] iterK;
	logic [16:0] iterSh;
	logic [50:0] iterP;
	logic [50:0] iterMag;
	logic [6:0]  iterLz;
	logic [50:0] iterNorm;
	fpau_word_t  mulRes_next;
	logic        mulErr_next;

	always_comb begin
		mulOvf = !mulExp_reg[16] && (mulExp_reg[15] || mulExp_reg[14:0] >= EXP_OVF); // RQ1
		mulUnf = mulExp_reg[16] || mulExp_reg[14:0] < EXP_UNF || mulProd_reg[95:94] == 2'b00; // RQ1
		if (mulProd_reg[95]) begin
			mulCoefN = mulProd_reg[95:48];
			mulExpN = mulExp_reg;
		end else begin
			mulCoefN = mulProd_reg[94:47]; // RQ15
			mulExpN = mulExp_reg - 17'h00001;
		end
		iterK = mulExpN - {2'b00, EXP_BIAS};
		iterSh = 17'(-iterK);
		if (!iterK[16] && iterK > 17'h00001) begin
			iterP = ITER_TWO;
		end else if (iterK == 17'h00001) begin
			iterP = {2'b00, mulCoefN, 1'b0};
		end else if (iterK == '0) begin
			iterP = {3'b000, mulCoefN};
		end else if (iterSh >= ITER_SHIFT_MAX) begin
			iterP = '0;
		end else begin
			iterP = {3'b000, mulCoefN} >> iterSh;
		end
		iterMag = mulSign_reg ? (ITER_TWO + iterP) : (ITER_TWO - iterP);
		iterLz = lzc64({iterMag, 13'h0000});
		iterNorm = iterMag << iterLz;
		mulErr_next = 1'b0;
		if (mulInt_reg) begin
			mulRes_next = '{mulSign_reg, 15'h0000, mulProd_reg[95:48]}; // RQ2 RQ3 RQ4
		end else if (mulOvf) begin
			mulRes_next = '{mulSign_reg, EXP_OVF, (mulMode_reg == MUL_HALF) ? (mulCoefN & HALF_MASK) : mulCoefN}; // RQ20
			mulErr_next = 1'b1;
		end else if (mulUnf) begin
			mulRes_next = '0;
		end else if (mulMode_reg == MUL_ITERATE) begin
			if (iterMag == '0) begin
				mulRes_next = '0; // RQ23
			end else begin
				mulRes_next = '{1'b0, 15'(ITER_EXP_BASE - {10'h000, iterLz}), iterNorm[50:3]}; // RQ23
			end
		end else if (mulMode_reg == MUL_HALF) begin
			mulRes_next = '{mulSign_reg, mulExpN[14:0], mulCoefN & HALF_MASK}; // RQ20
		end else begin
			mulRes_next = '{mulSign_reg, mulExpN[14:0], mulCoefN};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mulResValid <= 1'b0;
			mulRes <= '0;
			mulErr <= 1'b0;
		end else begin
			mulResValid <= mul1Valid_reg;
			mulRes <= mulRes_next;
			mulErr <= mulErr_next; // RQ26
		end
	end

	// ----------------------------------------
	// reciprocal: seed then three Newton stages
	// ----------------------------------------
	// each stage is its own register, so a new operand enters every cycle
	logic [31:0] rcpX_reg [1:3];
	logic [31:0] rcpB_reg [1:3];
	logic [14:0] rcpExp_reg [1:3];
	logic        rcpSign_reg [1:3];
	logic        rcpRange_reg [1:3];
	logic        rcpValid_reg [1:3];

	// the first stage reads the operand itself, so the seed lookup costs no cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int s = 1; s <= 3; s++) begin
				rcpX_reg[s] <= '0;
				rcpB_reg[s] <= '0;
				rcpExp_reg[s] <= '0;
				rcpSign_reg[s] <= 1'b0;
				rcpRange_reg[s] <= 1'b0;
				rcpValid_reg[s] <= 1'b0;
			end
		end else begin
			rcpX_reg[1] <= newtonStep({RCP_SEED[rcpOp.coef[46:44]], 16'h0000}, rcpOp.coef[47:16]); // RQ22 RQ21
			rcpB_reg[1] <= rcpOp.coef[47:16];
			rcpExp_reg[1] <= rcpOp.exp;
			rcpSign_reg[1] <= rcpOp.sign;
			rcpRange_reg[1] <= (rcpOp.exp <= RCP_ERR_LO) || (rcpOp.exp >= RCP_ERR_HI); // RQ6
			rcpValid_reg[1] <= rcpValid;
			for (int s = 2; s <= 3; s++) begin
				rcpX_reg[s] <= newtonStep(rcpX_reg[s - 1], rcpB_reg[s - 1]); // RQ22 RQ21
				rcpB_reg[s] <= rcpB_reg[s - 1];
				rcpExp_reg[s] <= rcpExp_reg[s - 1];
				rcpSign_reg[s] <= rcpSign_reg[s - 1];
				rcpRange_reg[s] <= rcpRange_reg[s - 1];
				rcpValid_reg[s] <= rcpValid_reg[s - 1];
			end
		end
	end

	logic [16:0] rcpExpN;
	logic [47:0] rcpCoefN;

	always_comb begin
		rcpExpN = RCP_EXP_BASE - {2'b00, rcpExp_reg[3]};
		if (rcpX_reg[3][31]) begin
			rcpCoefN = {rcpX_reg[3], 16'h0000};
			rcpExpN = rcpExpN + 17'h00001;
		end else begin
			rcpCoefN = {rcpX_reg[3][30:0], 17'h00000};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rcpResValid <= 1'b0;
			rcpRes <= '0;
			rcpErr <= 1'b0;
		end else begin
			rcpResValid <= rcpValid_reg[3]; // RQ21
			rcpErr <= rcpRange_reg[3]; // RQ26
			if (rcpRange_reg[3]) begin
				rcpRes <= '{rcpSign_reg[3], EXP_OVF, {1'b0, rcpCoefN[46:0]}}; // RQ7
			end else begin
				rcpRes <= '{rcpSign_reg[3], rcpExpN[14:0], rcpCoefN};
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_MUL_INT_EXP: assert property (@(posedge clk) disable iff (reset) // RQ2
		mulValid && mulOpA.exp == '0 && mulOpB.exp == '0 |-> ##2 mulResValid && mulRes.exp == '0)
		else $error("integer multiply returned nonzero exponent");
	AST_MUL_INT_COEF: assert property (@(posedge clk) disable iff (reset) // RQ3
		mul1Valid_reg && mulInt_reg |=> mulRes.coef == $past(mulProd_reg[95:48]))
		else $error("integer multiply coefficient not top product half");
	AST_MUL_INT_SIGN: assert property (@(posedge clk) disable iff (reset) // RQ4
		mulValid && mulOpA.exp == '0 && mulOpB.exp == '0 |-> ##2 mulRes.sign == $past(mulOpA.sign ^ mulOpB.sign, 2))
		else $error("integer multiply sign wrong");
	AST_MUL_HALF_LOW: assert property (@(posedge clk) disable iff (reset) // RQ20
		mulValid && mulMode == MUL_HALF && mulOpA.exp != '0 |-> ##2 mulRes.coef[18:0] == '0)
		else $error("half precision low bits not zero");
	AST_MUL_LAT: assert property (@(posedge clk) disable iff (reset) // RQ27
		mulValid ##1 mulValid |-> ##1 mulResValid ##1 mulResValid)
		else $error("multiply back to back results missing");
	AST_RCP_RANGE: assert property (@(posedge clk) disable iff (reset) // RQ6
		rcpValid && (rcpOp.exp <= RCP_ERR_LO || rcpOp.exp >= RCP_ERR_HI) |-> ##4 rcpErr && rcpResValid)
		else $error("reciprocal range error not flagged");
	AST_RCP_ERR_RES: assert property (@(posedge clk) disable iff (reset) // RQ7
		rcpResValid && rcpErr |-> rcpRes.exp == EXP_OVF && !rcpRes.coef[47])
		else $error("reciprocal error result malformed");
	AST_RCP_RATE: assert property (@(posedge clk) disable iff (reset) // RQ21
		rcpValid [*3] |-> ##2 rcpResValid [*3])
		else $error("reciprocal not one result per cycle");
	AST_ADD_NORM: assert property (@(posedge clk) disable iff (reset) // RQ12
		addResValid && !addErr && addRes.exp != '0 |-> addRes.coef[47])
		else $error("add result not normalized");
	AST_ADD_OVF: assert property (@(posedge clk) disable iff (reset) // RQ25
		addValid && (addOpA.exp >= EXP_OVF || addOpB.exp >= EXP_OVF) |-> ##2 addErr && addRes.exp == EXP_OVF)
		else $error("add overflow not flagged");
	AST_ADD_UNF: assert property (@(posedge clk) disable iff (reset) // RQ13
		addResValid && addRes == '0 |-> !addErr)
		else $error("add underflow flagged");

	COV_ADD_CARRY: cover property (@(posedge clk) disable iff (reset) add1Valid_reg && addSum_reg[48]);
	COV_MUL_HALF: cover property (@(posedge clk) disable iff (reset) mul1Valid_reg && mulMode_reg == MUL_HALF);
	COV_MUL_ITER: cover property (@(posedge clk) disable iff (reset) mul1Valid_reg && mulMode_reg == MUL_ITERATE);
	COV_RCP_ERR: cover property (@(posedge clk) disable iff (reset) rcpResValid && rcpErr);

endmodule

//--- fpau_issue_model.sv
`timescale 1ns/1ps
module fpau_issue_model
	import fpau_pkg::*;
(
	// clock
	input  wire logic       clk,
	// toward the units
	output logic            addValid,
	output fpau_word_t      addOpA,
	output fpau_word_t      addOpB,
	output logic            addSubtract,
	output logic            mulValid,
	output fpau_word_t      mulOpA,
	output fpau_word_t      mulOpB,
	output fpau_mul_mode_t  mulMode,
	output logic            rcpValid,
	output fpau_word_t      rcpOp,
	// from the units
	input  wire logic       addResValid,
	input  wire fpau_word_t addRes,
	input  wire logic       addErr,
	input  wire logic       mulResValid,
	input  wire fpau_word_t mulRes,
	input  wire logic       mulErr,
	input  wire logic       rcpResValid,
	input  wire fpau_word_t rcpRes,
	input  wire logic       rcpErr
);
	// ----------------------------------------
	// queues shared with the bench
	// ----------------------------------------
	logic [129:0] opQ [3][$];
	logic [72:0]  resQ [3][$];
	int           stampQ [3][$];
	logic [129:0] last [3];
	logic [2:0]   hit;
	int           cycleCnt = 0;

	always @(posedge clk) begin
		cycleCnt <= cycleCnt + 1;
	end

	// result word, flag and measured latency, logged in the cycle the result stands
	function automatic void logRes(input int u, input logic [64:0] v);
		int s;
		s = (stampQ[u].size() > 0) ? stampQ[u].pop_front() : 0;
		resQ[u].push_back({v, 8'(cycleCnt - s)});
	endfunction

	// ----------------------------------------
	// issue: one op per unit per cycle at most
	// ----------------------------------------
	task automatic step();
		logic [129:0] op [3];
		if (addResValid === 1'b1) logRes(0, {addRes, addErr});
		if (mulResValid === 1'b1) logRes(1, {mulRes, mulErr});
		if (rcpResValid === 1'b1) logRes(2, {rcpRes, rcpErr});
		for (int u = 0; u < 3; u++) begin
			hit[u] = opQ[u].size() > 0;
			// idle operands toggle so a unit never sees a stale word
			op[u] = ~last[u];
			if (hit[u]) begin
				op[u] = opQ[u].pop_front();
				stampQ[u].push_back(cycleCnt);
			end
			last[u] = op[u];
		end
		addValid = hit[0];
		mulValid = hit[1];
		rcpValid = hit[2];
		addOpA = op[0][129:66];
		addOpB = op[0][65:2];
		addSubtract = op[0][0];
		mulOpA = op[1][129:66];
		mulOpB = op[1][65:2];
		mulMode = fpau_mul_mode_t'(op[1][1:0]);
		rcpOp = op[2][129:66];
	endtask

	initial begin
		for (int u = 0; u < 3; u++) last[u] = '0;
		forever begin
			step();
			@(negedge clk);
		end
	end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top
	import fpau_pkg::*;
;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic           clk = 1'b0;
	logic           reset = 1'b1;
	logic           addValid, addSubtract, addResValid, addErr;
	fpau_word_t     addOpA, addOpB, addRes;
	logic           mulValid, mulResValid, mulErr;
	fpau_word_t     mulOpA, mulOpB, mulRes;
	fpau_mul_mode_t mulMode;
	logic           rcpValid, rcpResValid, rcpErr;
	fpau_word_t     rcpOp, rcpRes;
	int             n_errors = 0;
	int             checks = 0;

	fpau_units i_fpau_units (.clk(clk), .reset(reset),
		.addValid(addValid), .addOpA(addOpA), .addOpB(addOpB), .addSubtract(addSubtract),
		.addResValid(addResValid), .addRes(addRes), .addErr(addErr),
		.mulValid(mulValid), .mulOpA(mulOpA), .mulOpB(mulOpB), .mulMode(mulMode),
		.mulResValid(mulResValid), .mulRes(mulRes), .mulErr(mulErr),
		.rcpValid(rcpValid), .rcpOp(rcpOp), .rcpResValid(rcpResValid), .rcpRes(rcpRes), .rcpErr(rcpErr));

	fpau_issue_model i_fpau_issue_model (.clk(clk),
		.addValid(addValid), .addOpA(addOpA), .addOpB(addOpB), .addSubtract(addSubtract),
		.mulValid(mulValid), .mulOpA(mulOpA), .mulOpB(mulOpB), .mulMode(mulMode),
		.rcpValid(rcpValid), .rcpOp(rcpOp),
		.addResValid(addResValid), .addRes(addRes), .addErr(addErr),
		.mulResValid(mulResValid), .mulRes(mulRes), .mulErr(mulErr),
		.rcpResValid(rcpResValid), .rcpRes(rcpRes), .rcpErr(rcpErr));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic fpau_word_t fw(input logic s, input logic [14:0] e, input logic [47:0] c);
		return {s, e, c};
	endfunction

	// reference product: own arithmetic, injection before the normalizing shift
	function automatic fpau_word_t mulRef(input fpau_word_t a, input fpau_word_t b, input logic [1:0] m);
		logic [95:0] p;
		fpau_word_t  r;
		p = 96'(a.coef) * 96'(b.coef);
		if (m == 2'h1) p = p + (96'h3 << 45);
		else if (m == 2'h2) p = p + (96'h3 << 64);
		else p = p + (96'h9 << 40);
		r.sign = a.sign ^ b.sign;
		r.exp = a.exp + b.exp - 15'h4000;
		r.coef = p[95:48];
		if (!p[95]) begin
			r.coef = p[94:47];
			r.exp = r.exp - 15'h0001;
		end
		if (m == 2'h2) r.coef[18:0] = 19'h0;
		return r;
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic issue(input int u, input fpau_word_t a, input fpau_word_t b, input logic [1:0] c);
		i_fpau_issue_model.opQ[u].push_back({a, b, c});
	endtask

	// approximate results (reciprocal, multiply iteration mode) get a coefficient tolerance, everything else is exact
	task automatic expectRes(input int u, input fpau_word_t w, input logic e, input int lat,
		input logic [47:0] tol = 48'h0);
		logic [72:0] r;
		fpau_word_t  got;
		logic [47:0] d;
		int          n;
		n = 0;
		while (i_fpau_issue_model.resQ[u].size() == 0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (i_fpau_issue_model.resQ[u].size() == 0) begin
			n_errors++;
			$display("[ERR] %0t no result from unit %0d", $time, u);
			stop_test();
		end else begin
			r = i_fpau_issue_model.resQ[u].pop_front();
			got = r[72:9];
			d = (got.coef > w.coef) ? got.coef - w.coef : w.coef - got.coef;
			if (d <= tol) got.coef = w.coef;
			check(got, w, "result word");
			check(64'(r[8]), 64'(e), "range flag");
			check(64'(r[7:0]), 64'(lat), "latency");
		end
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		fpau_word_t  one, two, p;
		fpau_word_t  mp [2];
		fpau_word_t  mq [2];
		logic [14:0] re [7];
		one = fw(1'b0, 15'h4001, 48'h800000000000);
		two = fw(1'b0, 15'h4002, 48'h800000000000);
		mp = '{fw(1'b0, 15'h4000, 48'hC00000000001), fw(1'b0, 15'h4001, 48'h9ABCDEF01235)};
		mq = '{fw(1'b1, 15'h4000, 48'hAAAAAAAAAAAB), fw(1'b0, 15'h3FFF, 48'h876543210FED)};
		re = '{15'h2001, 15'h6002, 15'h0000, 15'h7FFF, 15'h2002, 15'h4002, 15'h6001};
		repeat (10) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		// add unit, all back to back
		issue(0, one, one, 2'h0);
		issue(0, one, one, 2'h1);
		issue(0, one, 64'h0, 2'h0);
		issue(0, fw(1'b0, 15'h4030, 48'h000000000005), 64'h0, 2'h0);
		issue(0, one, fw(1'b0, 15'h4000, 48'h800000000001), 2'h0);
		issue(0, fw(1'b0, 15'h4000, 48'hC00000000000), fw(1'b1, 15'h4002, 48'h800000000000), 2'h0);
		issue(0, two, fw(1'b0, 15'h4000, 48'hC00000000000), 2'h1);
		issue(0, one, fw(1'b0, 15'h3FD0, 48'hFFFFFFFFFFFF), 2'h0);
		issue(0, fw(1'b0, 15'h6000, 48'h800000000000), one, 2'h0);
		issue(0, fw(1'b0, 15'h5FFF, 48'h800000000000), fw(1'b0, 15'h5FFF, 48'h800000000000), 2'h0);
		issue(0, fw(1'b0, 15'h2000, 48'h800000000000), fw(1'b0, 15'h2000, 48'h400000000000), 2'h1);
		expectRes(0, two, 1'b0, 2);
		expectRes(0, 64'h0, 1'b0, 2);
		expectRes(0, one, 1'b0, 2);
		expectRes(0, fw(1'b0, 15'h4003, 48'hA00000000000), 1'b0, 2);
		expectRes(0, fw(1'b0, 15'h4001, 48'hC00000000000), 1'b0, 2);
		expectRes(0, fw(1'b1, 15'h4001, 48'hA00000000000), 1'b0, 2);
		expectRes(0, fw(1'b0, 15'h4001, 48'hA00000000000), 1'b0, 2);
		expectRes(0, one, 1'b0, 2);
		expectRes(0, fw(1'b0, 15'h6000, 48'h800000000000), 1'b1, 2);
		expectRes(0, fw(1'b0, 15'h6000, 48'h800000000000), 1'b1, 2);
		expectRes(0, 64'h0, 1'b0, 2);
		$display("test add done");
		// multiply: integer, normalizing, overflow, iteration; first integer pair as 24-bit upper-half integers, second uses an all-ones coefficient
		issue(1, fw(1'b1, 15'h0, 48'h000004000000), fw(1'b0, 15'h0, 48'h000006000000), 2'h0);
		issue(1, fw(1'b0, 15'h0, 48'hFFFFFFFFFFFF), fw(1'b0, 15'h0, 48'h000001000000), 2'h0);
		issue(1, one, one, 2'h0);
		issue(1, fw(1'b0, 15'h4001, 48'hC00000000000), fw(1'b0, 15'h4001, 48'hC00000000000), 2'h0);
		issue(1, fw(1'b0, 15'h5000, 48'h800000000000), fw(1'b0, 15'h5000, 48'h800000000000), 2'h0);
		issue(1, one, fw(1'b0, 15'h4000, 48'h800000000000), 2'h3);
		expectRes(1, fw(1'b1, 15'h0, 48'h000000000018), 1'b0, 2);
		expectRes(1, fw(1'b0, 15'h0, 48'h000001000000), 1'b0, 2);
		expectRes(1, one, 1'b0, 2);
		expectRes(1, fw(1'b0, 15'h4002, 48'h900000000000), 1'b0, 2);
		expectRes(1, fw(1'b0, 15'h6000, 48'h800000000000), 1'b1, 2);
		expectRes(1, fw(1'b0, 15'h4001, 48'hC00000000000), 1'b0, 2, 48'h2);
		// every rounding mode, both operand orders, one op per cycle
		for (int i = 0; i < 6; i++) begin
			issue(1, mp[i % 2], mq[i % 2], 2'(i / 2));
			issue(1, mq[i % 2], mp[i % 2], 2'(i / 2));
		end
		for (int i = 0; i < 6; i++) begin
			p = mulRef(mp[i % 2], mq[i % 2], 2'(i / 2));
			expectRes(1, p, 1'b0, 2);
			expectRes(1, p, 1'b0, 2);
		end
		$display("test multiply done");
		// reciprocal of 0.75 at several exponents, streamed every cycle
		for (int i = 0; i < 7; i++) issue(2, fw(i[0], re[i], 48'hC00000000000), 64'h0, 2'h0);
		for (int i = 0; i < 4; i++) begin
			expectRes(2, fw(i[0], 15'h6000, 48'h2AAAAAAAAAAB), 1'b1, 4, 48'h100000);
		end
		for (int i = 4; i < 7; i++) begin
			p = fw(i[0], 15'(17'h08001 - 17'(re[i])), 48'hAAAAAAAAAAAB);
			expectRes(2, p, 1'b0, 4, 48'h100000);
		end
		$display("test reciprocal done");
		// a second reset while an add is in flight clears the outputs at once
		issue(0, one, one, 2'h0);
		repeat (2) @(negedge clk);
		reset = 1'b1;
		#1;
		check(64'({addResValid, mulResValid, rcpResValid}), 64'h0, "valid in reset");
		check(addRes, 64'h0, "result in reset");
		$display("test reset done");
		stop_test();
	end
endmodule
